// *** socket_status_change.sv ***
// Purpose: One socket's card status change flags and interrupt request
// Assumes: Inputs synchronous to clock; debounced card detect supplied outside
// Notes: Set beats clear in the same cycle
`timescale 1ns/1ns
`include "card_status_change_regs.svh"
module socket_status_change
    import card_status_change_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Configuration
    input wire logic io_card,
    input wire logic explicit_write_back,
    input wire logic timer_compat_enable,
    input wire logic input_change_enable,
    input wire logic input_edge_select,
    input wire logic detect_enable,
    input wire logic ready_enable,
    input wire logic warn_enable,
    input wire logic dead_enable,
    input wire logic ring_indicate_enable,
    // Card and timer events
    input wire logic timer_expired,
    input wire logic general_purpose_input,
    input wire logic [1:0] card_detect_pins,
    input wire logic card_ready,
    input wire logic [1:0] battery_voltage_detect,
    input wire logic card_change_ring_line,
    // Register access
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    // Results
    output logic [7:0] flags,
    output logic irq
);
    logic [7:0] flags_r;
    logic [7:0] set_ev;
    logic [7:0] clr;
    logic [7:0] qual;
    logic gpi_d_r;
    logic [1:0] cd_d_r;
    logic rdy_d_r;
    logic [1:0] bvd_d_r;
    logic ring_d_r;
    logic pend_r;
    logic bat_warn;
    logic bat_dead;

    ////////////////////////////////////////////////////////////////////////////
    // Battery decode
    assign bat_warn = (battery_voltage_detect == `BVD_WARN);
    assign bat_dead = ~battery_voltage_detect[0]; // 00 and 10 both dead

    // Previous input levels for edge detection
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gpi_d_r <= 1'b0;
            cd_d_r <= 2'b00;
            rdy_d_r <= 1'b0;
            bvd_d_r <= 2'b11;
            ring_d_r <= 1'b1;
        end else begin
            gpi_d_r <= general_purpose_input;
            cd_d_r <= card_detect_pins;
            rdy_d_r <= card_ready;
            bvd_d_r <= battery_voltage_detect;
            ring_d_r <= card_change_ring_line;
        end
    end

    // Qualifying enables; a disabled flag is forced to zero
    always_comb begin
        qual = 8'h00;
        qual[`CSC_BIT_TIMEOUT] = timer_compat_enable;
        qual[`CSC_BIT_INPUT] = input_change_enable;
        qual[`CSC_BIT_DETECT] = detect_enable;
        qual[`CSC_BIT_READY] = ready_enable & ~io_card;
        qual[`CSC_BIT_WARN] = warn_enable & ~io_card;
        qual[`CSC_BIT_DEAD] = io_card ? ~ring_indicate_enable : dead_enable;
    end

    // Event detection; battery events fire on entering the condition
    always_comb begin
        set_ev = 8'h00;
        set_ev[`CSC_BIT_TIMEOUT] = timer_expired;
        set_ev[`CSC_BIT_INPUT] = input_edge_select ? (general_purpose_input & ~gpi_d_r)
                                                   : (~general_purpose_input & gpi_d_r);
        set_ev[`CSC_BIT_DETECT] = |(card_detect_pins ^ cd_d_r);
        set_ev[`CSC_BIT_READY] = card_ready & ~rdy_d_r;
        set_ev[`CSC_BIT_WARN] = bat_warn & (bvd_d_r != `BVD_WARN);
        if (io_card) begin
            set_ev[`CSC_BIT_DEAD] = ~card_change_ring_line & ring_d_r;
        end else begin
            set_ev[`CSC_BIT_DEAD] = bat_dead & bvd_d_r[0];
        end
        set_ev = set_ev & qual & ~`CSC_RESERVED_MASK;
    end

    // Clear by write-one-back or by read of the set bits
    always_comb begin
        clr = 8'h00;
        if (explicit_write_back && wr_stb) begin
            clr = wr_data;
        end else if (!explicit_write_back && rd_stb) begin
            clr = flags;
        end
    end

    // Flag storage; new event wins over a clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_r <= `CSC_RESET;
        end else begin
            flags_r <= ((flags_r & ~clr) | set_ev) & qual;
        end
    end

    // Read-pending latch for clear-on-read interrupt mode
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pend_r <= 1'b0;
        end else if (|set_ev) begin
            pend_r <= 1'b1;
        end else if (rd_stb) begin
            pend_r <= 1'b0;
        end
    end

    assign flags = flags_r & qual;
    // Write-back mode holds until all zero; otherwise until read
    assign irq = explicit_write_back ? (|flags) : (pend_r & (|flags));
endmodule : socket_status_change

// *** card_status_change_regs.svh ***
// Purpose: Offsets, field positions and reset values of the status change block
// Assumes: Byte-wide index register port, two sockets
// Notes: Definitions only
`ifndef CARD_STATUS_CHANGE_REGS_SVH
`define CARD_STATUS_CHANGE_REGS_SVH

`define CSC_OFFSET_A 8'h04
`define CSC_OFFSET_B 8'h44
`define CSC_BIT_TIMEOUT 7
`define CSC_BIT_INPUT 4
`define CSC_BIT_DETECT 3
`define CSC_BIT_READY 2
`define CSC_BIT_WARN 1
`define CSC_BIT_DEAD 0
`define CSC_RESERVED_MASK 8'h60
`define CSC_RESET 8'h00
`define BVD_GOOD 2'b11
`define BVD_WARN 2'b01

`endif

// *** card_status_change_pkg.sv ***
// Purpose: Types shared by the status change block
// Assumes: Nothing beyond the register header
// Notes: Card kind of a socket
package card_status_change_pkg;
    typedef enum logic [1:0] {
        CARD_MEMORY = 2'b01,
        CARD_IO = 2'b10
    } card_kind_t;
endpackage : card_status_change_pkg

// *** card_status_change_irq.sv ***
// Purpose: Two-socket card status change register behind the index port
// Assumes: Index port gives byte index, read and write strobes one cycle wide
// Notes: Read data registered; other indexes are served elsewhere
`timescale 1ns/1ns
`include "card_status_change_regs.svh"
module card_status_change_irq
    import card_status_change_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Index register port
    input wire logic [7:0] reg_index,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Global configuration
    input wire logic explicit_write_back,
    // Socket configuration: card kind per socket, then bit per socket [0]=A [1]=B
    input wire card_kind_t card_kind_a,
    input wire card_kind_t card_kind_b,
    input wire logic [1:0] timer_compat_enable,
    input wire logic [1:0] input_change_enable,
    input wire logic [1:0] input_edge_select,
    input wire logic [1:0] detect_enable,
    input wire logic [1:0] ready_enable,
    input wire logic [1:0] warn_enable,
    input wire logic [1:0] dead_enable,
    input wire logic [1:0] ring_indicate_enable,
    // Card and timer events
    input wire logic [1:0] timer_expired,
    input wire logic [1:0] general_purpose_input,
    input wire logic [1:0] card_detect_pins_a,
    input wire logic [1:0] card_detect_pins_b,
    input wire logic [1:0] card_ready,
    input wire logic [1:0] battery_voltage_detect_a,
    input wire logic [1:0] battery_voltage_detect_b,
    input wire logic [1:0] card_change_ring_line,
    // Interrupt requests per socket
    output logic [1:0] status_irq
);
    logic sel_a;
    logic sel_b;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Index decode
    assign sel_a = (reg_index == `CSC_OFFSET_A);
    assign sel_b = (reg_index == `CSC_OFFSET_B);
    assign reg_hit = sel_a | sel_b;

    ////////////////////////////////////////////////////////////////////////////
    // Socket instances
    socket_status_change u_sock_a (
        .clock(clock),
        .nrst(nrst),
        .io_card(card_kind_a == CARD_IO),
        .explicit_write_back(explicit_write_back),
        .timer_compat_enable(timer_compat_enable[0]),
        .input_change_enable(input_change_enable[0]),
        .input_edge_select(input_edge_select[0]),
        .detect_enable(detect_enable[0]),
        .ready_enable(ready_enable[0]),
        .warn_enable(warn_enable[0]),
        .dead_enable(dead_enable[0]),
        .ring_indicate_enable(ring_indicate_enable[0]),
        .timer_expired(timer_expired[0]),
        .general_purpose_input(general_purpose_input[0]),
        .card_detect_pins(card_detect_pins_a),
        .card_ready(card_ready[0]),
        .battery_voltage_detect(battery_voltage_detect_a),
        .card_change_ring_line(card_change_ring_line[0]),
        .rd_stb(reg_rd & sel_a),
        .wr_stb(reg_wr & sel_a),
        .wr_data(reg_wdata),
        .flags(flags_a),
        .irq(status_irq[0])
    );

    socket_status_change u_sock_b (
        .clock(clock),
        .nrst(nrst),
        .io_card(card_kind_b == CARD_IO),
        .explicit_write_back(explicit_write_back),
        .timer_compat_enable(timer_compat_enable[1]),
        .input_change_enable(input_change_enable[1]),
        .input_edge_select(input_edge_select[1]),
        .detect_enable(detect_enable[1]),
        .ready_enable(ready_enable[1]),
        .warn_enable(warn_enable[1]),
        .dead_enable(dead_enable[1]),
        .ring_indicate_enable(ring_indicate_enable[1]),
        .timer_expired(timer_expired[1]),
        .general_purpose_input(general_purpose_input[1]),
        .card_detect_pins(card_detect_pins_b),
        .card_ready(card_ready[1]),
        .battery_voltage_detect(battery_voltage_detect_b),
        .card_change_ring_line(card_change_ring_line[1]),
        .rd_stb(reg_rd & sel_b),
        .wr_stb(reg_wr & sel_b),
        .wr_data(reg_wdata),
        .flags(flags_b),
        .irq(status_irq[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data captured on the read strobe, reserved bits masked
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            if (sel_a) begin
                rdata_r <= flags_a & ~`CSC_RESERVED_MASK;
            end else if (sel_b) begin
                rdata_r <= flags_b & ~`CSC_RESERVED_MASK;
            end else begin
                rdata_r <= 8'h00; // Unmapped index reads zero
            end
        end
    end

    assign reg_rdata = rdata_r;
endmodule : card_status_change_irq

// *** card_status_change_irq_sva.sv ***
// Purpose: Socket A flag, irq and read data relations
// Assumes: Bound to card_status_change_irq, config held steady around events
// Notes: Socket B shares the logic, so only A is watched, except the reserved-bit check on reads of either socket
`timescale 1ns/1ns
`include "card_status_change_regs.svh"
module card_status_change_irq_sva
    import card_status_change_pkg::*;
(
    // Clock, reset and index port
    input wire logic clock, nrst, reg_rd, reg_hit, explicit_write_back,
    input wire logic [7:0] reg_index, reg_rdata,
    // Socket configuration, events and requests
    input wire card_kind_t card_kind_a,
    input wire logic [1:0] timer_compat_enable, timer_expired, input_change_enable,
    input wire logic [1:0] input_edge_select, general_purpose_input, ready_enable,
    input wire logic [1:0] card_ready, ring_indicate_enable, card_change_ring_line,
    input wire logic [1:0] dead_enable, battery_voltage_detect_a, status_irq
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!nrst);
    // Decodes shared by several properties
    wire rd_a = reg_rd && (reg_index == `CSC_OFFSET_A);
    wire mem_a = card_kind_a == CARD_MEMORY;
    wire io_a = card_kind_a == CARD_IO;
    ////////////////////////////////////////////////////////////////////////////
    property p_timeout; timer_expired[0] && timer_compat_enable[0] |=> status_irq[0]; endproperty
    a_timeout: assert property (p_timeout) else $error("timer expiry raised no irq");
    property p_input;
        input_change_enable[0] && input_edge_select[0] && $rose(general_purpose_input[0])
        |=> status_irq[0];
    endproperty
    a_input: assert property (p_input) else $error("input edge raised no irq");
    property p_ready; mem_a && ready_enable[0] && $rose(card_ready[0]) |=> status_irq[0]; endproperty
    a_ready: assert property (p_ready) else $error("ready rise raised no irq");
    // Falling low bit of the detect pair means entering 00 or 10
    property p_dead;
        mem_a && dead_enable[0] && $fell(battery_voltage_detect_a[0]) |=> status_irq[0];
    endproperty
    a_dead: assert property (p_dead) else $error("battery dead raised no irq");
    property p_ring;
        io_a && !ring_indicate_enable[0] && $fell(card_change_ring_line[0]) |=> status_irq[0];
    endproperty
    a_ring: assert property (p_ring) else $error("ring line low raised no irq");
    property p_io_quiet; io_a [*2] ##0 rd_a |=> reg_rdata[2:1] == 2'b00; endproperty
    a_io_quiet: assert property (p_io_quiet) else $error("I/O card shows ready or warn");
    property p_keep; explicit_write_back && status_irq[0] && rd_a |=> status_irq[0]; endproperty
    a_keep: assert property (p_keep) else $error("read dropped irq in write-back mode");
    property p_reserved; reg_rd && reg_hit |=> reg_rdata[6:5] == 2'b00; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
endmodule : card_status_change_irq_sva

// *** card_pins.sv ***
// Purpose: Card in the socket, driving its status pins
// Assumes: Pins change 2 ns after a rising edge
// Notes: Ring line idles high, as with the card's pull-up
`timescale 1ns/1ns
module card_pins (
    // Clock
    input wire logic clock,
    // Card pins
    output logic ready,
    output logic gp_in,
    output logic ring_n,
    output logic [1:0] detect,
    output logic [1:0] batt
);
    // Idle card: busy, no detect, battery good, ring released
    initial {ready, gp_in, ring_n, detect, batt} = 7'b0010011;
    // Launched just after an edge so the sampling edge never races it
    task automatic drive(input logic [6:0] v);
        @(posedge clock);
        #2 {ready, gp_in, ring_n, detect, batt} = v;
    endtask : drive
endmodule : card_pins

// *** tb_top.sv ***
// Purpose: Self-checking bench for the two-socket status change register
// Assumes: Each socket has its own card model, timer pulse and enables
// Notes: Pin vector is {ready, gp_in, ring_n, detect, batt}
`timescale 1ns/1ns
`include "card_status_change_regs.svh"
module tb_top
    import card_status_change_pkg::*;
;
    logic clock = 1'b0, nrst = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, ewb = 1'b0, tmr = 1'b0;
    logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, en = 8'h00, reg_rdata;
    logic [1:0] status_irq, detect, batt;
    logic ready, gp_in, ring_n;
    card_kind_t kind = CARD_MEMORY;
    // Socket B has its own card, timer and enables, so cross-talk would show
    logic tmr_b = 1'b0, reg_hit, ready_b, gp_in_b, ring_n_b;
    logic [7:0] en_b = 8'h00;
    logic [1:0] detect_b, batt_b;
    card_kind_t kind_b = CARD_MEMORY;
    int errors = 0;
    int comparisons = 0;
    always #25 clock = ~clock;
    card_pins u_card_pins (.clock(clock), .ready(ready), .gp_in(gp_in), .ring_n(ring_n),
        .detect(detect), .batt(batt));
    card_pins u_card_pins_b (.clock(clock), .ready(ready_b), .gp_in(gp_in_b), .ring_n(ring_n_b),
        .detect(detect_b), .batt(batt_b));
    // Enables packed as en: 7 compat, 6 ring, 5 edge, 4 input, 3 detect, 2 ready, 1 warn, 0 dead
    card_status_change_irq u_card_status_change_irq (.clock(clock), .nrst(nrst),
        .reg_index(reg_index), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .explicit_write_back(ewb), .card_kind_a(kind),
        .card_kind_b(kind_b), .timer_compat_enable({en_b[7], en[7]}),
        .input_change_enable({en_b[4], en[4]}), .input_edge_select({en_b[5], en[5]}),
        .detect_enable({en_b[3], en[3]}), .ready_enable({en_b[2], en[2]}),
        .warn_enable({en_b[1], en[1]}), .dead_enable({en_b[0], en[0]}),
        .ring_indicate_enable({en_b[6], en[6]}), .timer_expired({tmr_b, tmr}),
        .general_purpose_input({gp_in_b, gp_in}), .card_detect_pins_a(detect),
        .card_detect_pins_b(detect_b), .card_ready({ready_b, ready}),
        .battery_voltage_detect_a(batt), .battery_voltage_detect_b(batt_b),
        .card_change_ring_line({ring_n_b, ring_n}), .status_irq(status_irq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge clock);
        #2;
    endtask : tick
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // Strobe stands for exactly the one edge that takes it
    task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        tick;
        reg_index = idx;
        reg_wdata = d;
        reg_rd = !wr;
        reg_wr = wr;
        tick;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
    endtask : access
    task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
        access(1'b0, idx, 8'h00);
        cmp(reg_rdata, exp);
    endtask : chk
    // Same pin change on both cards at the same edge
    task automatic pins(input logic [6:0] v);
        fork
            u_card_pins.drive(v);
            u_card_pins_b.drive(v);
        join
    endtask : pins
    // Same enables on both sockets
    task automatic cfg(input logic [7:0] e);
        en = e;
        en_b = e;
    endtask : cfg
    task automatic both(input logic [7:0] exp);
        chk(`CSC_OFFSET_A, exp);
        chk(`CSC_OFFSET_B, exp);
    endtask : both
    task automatic test_done;
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // Cuts a hang short; the sequence needs under a hundred cycles
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge clock);
        #2 nrst = 1'b1;
        // Pin activity with every source disabled leaves nothing; rising input edge chosen
        cfg(8'h20);
        pins(7'b1110101);
        both(`CSC_RESET);
        cmp({7'h00, reg_hit}, 8'h01);
        pins(7'b1110001);
        both(`CSC_RESET);
        chk(8'h05, 8'h00);
        cmp({7'h00, reg_hit}, 8'h00);
        // Falling input with rising edge chosen is no event
        cfg(8'hbf);
        pins(7'b0010011);
        both(8'h00);
        // Four sources at once, irq until read, read clears
        pins(7'b1110101);
        tick;
        cmp({6'h00, status_irq}, 8'h03);
        both(8'h1e);
        cmp({6'h00, status_irq}, 8'h00);
        both(8'h00);
        // Timer counts only with the compatibility bit
        cfg(8'h3f);
        {tmr, tmr_b} = 2'b11;
        tick;
        {tmr, tmr_b} = 2'b00;
        both(8'h00);
        cfg(8'hbf);
        pins(7'b0110100);
        {tmr, tmr_b} = 2'b11;
        tick;
        {tmr, tmr_b} = 2'b00;
        both(8'h81);
        // Ready rise on the very edge of the clearing read
        fork
            chk(`CSC_OFFSET_A, 8'h00);
            pins(7'b1110100);
        join
        chk(`CSC_OFFSET_A, 8'h04);
        chk(`CSC_OFFSET_B, 8'h04);
        // Write-one-to-clear: reads keep flags, reserved writes ignored
        ewb = 1'b1;
        pins(7'b0110100);
        pins(7'b1110100);
        chk(`CSC_OFFSET_A, 8'h04);
        chk(`CSC_OFFSET_A, 8'h04);
        access(1'b1, `CSC_OFFSET_A, 8'h60);
        chk(`CSC_OFFSET_A, 8'h04);
        access(1'b1, `CSC_OFFSET_A, 8'h04);
        cmp({6'h00, status_irq}, 8'h02);
        chk(`CSC_OFFSET_A, 8'h00);
        access(1'b1, `CSC_OFFSET_B, 8'h04);
        // I/O card: ring line reports, ready and battery stay silent
        ewb = 1'b0;
        kind = CARD_IO;
        kind_b = CARD_IO;
        pins(7'b0110100);
        pins(7'b1100101);
        both(8'h01);
        cfg(8'hff);
        pins(7'b1110101);
        pins(7'b1100101);
        both(8'h00);
        // Each socket sees only its own card and timer
        cfg(8'hbf);
        u_card_pins.drive(7'b1110101);
        u_card_pins.drive(7'b1100101);
        tmr_b = 1'b1;
        tick;
        tmr_b = 1'b0;
        tick;
        cmp({6'h00, status_irq}, 8'h03);
        chk(`CSC_OFFSET_A, 8'h01);
        chk(`CSC_OFFSET_B, 8'h80);
        test_done;
    end
endmodule : tb_top
bind card_status_change_irq card_status_change_irq_sva u_card_status_change_irq_sva (.*);
